// [core/snvs_pkg.sv]
/*
  Constants for the serial nonvolatile SRAM core: array size, opcodes,
  status byte layout, reset values and the state encodings of both domains.
  Assumes a single core file that refers to every name as snvs_pkg::name.
*/
package snvs_pkg;

  // ----------------------------------------------------------------
  // array
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int DEPTH = 8192;
  localparam logic [12:0] LAST_ADDR = 13'h1FFF;
  localparam logic [12:0] ZERO_ADDR = 13'h0000;
  localparam logic [7:0] CELL_RST = 8'h00;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_STATUS_WR = 8'h01;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE_OFF = 8'h04;
  localparam logic [7:0] OP_STATUS_RD = 8'h05;
  localparam logic [7:0] OP_WRITE_ON = 8'h06;
  localparam logic [7:0] OP_AUTOSAVE_OFF = 8'h19;
  localparam logic [7:0] OP_SAVE = 8'h3C;
  localparam logic [7:0] OP_AUTOSAVE_ON = 8'h59;
  localparam logic [7:0] OP_RESTORE = 8'h60;

  // ----------------------------------------------------------------
  // status byte fields
  // ----------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_WEN = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 3;
  localparam int ST_PIN_EN = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic AUTOSAVE_RST = 1'b1;
  localparam logic [1:0] BP_RST = 2'h0;
  localparam logic PIN_EN_RST = 1'b0;
  localparam logic [2:0] BIT_RST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    L_OPC = 7'h01,
    L_ADDR = 7'h02,
    L_WDATA = 7'h04,
    L_RDATA = 7'h08,
    L_STAT_RD = 7'h10,
    L_STAT_WR = 7'h20,
    L_SKIP = 7'h40
  } snvs_link_state_type;

  typedef enum logic [4:0] {
    N_IDLE = 5'h01,
    N_ERASE = 5'h02,
    N_PROGRAM = 5'h04,
    N_CLEAR = 5'h08,
    N_COPY = 5'h10
  } snvs_nv_state_type;

endpackage : snvs_pkg

// [core/snvs_core.sv]
/*
  Serial nonvolatile SRAM core: serial slave on the link clock, SRAM and
  nonvolatile shadow arrays, save/restore sequencer and protection on clk.
  Assumes sck comes from the master and may stop outside frames, csN is
  the active-low select, and powerGood reflects the supply threshold.
*/
// What this block does
// - holds 8192 individually addressed bytes for serial reads and writes
// - serial slave only, supporting clock modes 0 and 3
// - write is opcode, two address bytes, data byte; no wait
// - burst writes go to consecutive addresses, wrapping to 0x0000
// - read is opcode and two address bytes; data follows immediately
// - burst reads return incrementing addresses, wrapping to 0x0000
// - save erases the shadow, then programs it; access blocked meanwhile
// - ready status bit reads 1 during any save or restore
// - power-loss save skipped unless a write happened since last save/restore
// - save command always saves
// - below threshold, block access and do conditional save if enabled
// - restore clears SRAM then copies shadow; shadow unchanged
// - power rising starts an automatic restore with access blocked
// - autosave off and on commands; volatile unless saved afterwards
// - power-up restore always happens
// - autosave enabled from the factory; every cell holds 0x00
// - pause pin freezes the serial sequence so it can resume
// - protect pin, write-disable and quarter/half/full block protection
// - bus mode taken from clock level at select fall
// - address MSB first in two bytes; top three bits ignored
// - unknown opcode ignored with output off until next select
`timescale 1ns/1ps
`default_nettype none

module snvs_core (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic csN,
  input wire logic si,
  input wire logic holdN,
  input wire logic wpN,
  input wire logic powerGood,
  output logic soOut,
  output logic soOe,
  output logic busyOut,
  output logic autosaveOn
);

  // ----------------------------------------------------------------
  // storage and clk-domain state
  // ----------------------------------------------------------------
  logic [7:0] sram [snvs_pkg::DEPTH];
  logic [7:0] nvArr [snvs_pkg::DEPTH];
  snvs_pkg::snvs_nv_state_type nvStateQ, nvStateD;
  logic [12:0] idxQ;
  logic wenQ, wpenQ, autosaveQ, dirtyQ, busyQ;
  logic [1:0] bpQ;
  logic nvWpenQ, nvAutosaveQ;
  logic [1:0] nvBpQ;
  logic pgS1Q, pgS2Q, pgPrevQ, wpS1Q, wpS2Q;
  logic evS1Q, evS2Q, evS3Q;

  // ----------------------------------------------------------------
  // link-domain state
  // ----------------------------------------------------------------
  snvs_pkg::snvs_link_state_type stateQ, stateD;
  logic [2:0] bitCntQ;
  logic [7:0] shiftQ;
  logic [12:0] addrQ;
  logic addrByteQ, isReadQ, seenRiseQ, mode3Q;
  logic holdS1Q, holdS2Q;
  logic [5:0] statS1Q, statS2Q;
  logic evTogQ;
  logic [7:0] evCodeQ, evDataQ;
  logic [12:0] evAddrQ;
  logic [7:0] txQ;
  logic soOutQ, soOeQ;

  // ----------------------------------------------------------------
  // link decode
  // ----------------------------------------------------------------
  wire holdActive = ~holdS2Q;
  wire byteDone = bitCntQ == snvs_pkg::BIT_LAST;
  wire [7:0] rxByte = {shiftQ[6:0], si};
  wire linkBusy = statS2Q[snvs_pkg::ST_BUSY];
  wire linkBlocked = statS2Q[5];
  wire memBlocked = linkBusy | linkBlocked;
  wire [7:0] statByte = {statS2Q[4], 3'h0, statS2Q[3:0]};
  wire sending = (stateQ == snvs_pkg::L_RDATA) | (stateQ == snvs_pkg::L_STAT_RD);
  wire txLoad = sending & (bitCntQ == snvs_pkg::BIT_RST);
  // the array read port is asynchronous: the clk side only writes it on a
  // posted event or a sweep, neither of which overlaps a granted read
  wire [7:0] memRdByte = sram[addrQ];
  wire [7:0] txSrc = (stateQ == snvs_pkg::L_STAT_RD) ? statByte : memRdByte;
  // mode 3 idles high: a falling edge before the first rising one is not data
  wire fallOk = ~mode3Q | seenRiseQ;
  logic postEv;
  logic [7:0] postCode;

  always_comb begin
    stateD = stateQ;
    postEv = 1'b0;
    postCode = rxByte;
    if (byteDone) begin
      case (stateQ)
        snvs_pkg::L_OPC: begin
          case (rxByte)
            snvs_pkg::OP_READ, snvs_pkg::OP_WRITE: begin
              stateD = memBlocked ? snvs_pkg::L_SKIP : snvs_pkg::L_ADDR;
            end
            snvs_pkg::OP_STATUS_RD: stateD = snvs_pkg::L_STAT_RD;
            snvs_pkg::OP_STATUS_WR: stateD = snvs_pkg::L_STAT_WR;
            snvs_pkg::OP_WRITE_ON, snvs_pkg::OP_WRITE_OFF, snvs_pkg::OP_SAVE,
            snvs_pkg::OP_RESTORE, snvs_pkg::OP_AUTOSAVE_ON,
            snvs_pkg::OP_AUTOSAVE_OFF: begin
              stateD = snvs_pkg::L_SKIP;
              postEv = 1'b1;
            end
            default: stateD = snvs_pkg::L_SKIP;
          endcase
        end
        snvs_pkg::L_ADDR: begin
          if (addrByteQ) begin
            stateD = isReadQ ? snvs_pkg::L_RDATA : snvs_pkg::L_WDATA;
          end
        end
        snvs_pkg::L_WDATA: begin
          postEv = 1'b1;
          postCode = snvs_pkg::OP_WRITE;
        end
        snvs_pkg::L_STAT_WR: begin
          postEv = 1'b1;
          postCode = snvs_pkg::OP_STATUS_WR;
          stateD = snvs_pkg::L_SKIP;
        end
        default: stateD = stateQ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // link receive, rising sck; select high clears the frame
  // ----------------------------------------------------------------
  always_ff @(posedge sck or posedge csN) begin
    if (csN) begin
      stateQ <= snvs_pkg::L_OPC;
      bitCntQ <= snvs_pkg::BIT_RST;
      shiftQ <= snvs_pkg::CELL_RST;
      addrQ <= snvs_pkg::ZERO_ADDR;
      addrByteQ <= 1'b0;
      isReadQ <= 1'b0;
      seenRiseQ <= 1'b0;
    end else if (!holdActive) begin
      seenRiseQ <= 1'b1;
      shiftQ <= rxByte;
      bitCntQ <= bitCntQ + 3'h1;
      stateQ <= stateD;
      if (byteDone && stateQ == snvs_pkg::L_OPC) begin
        isReadQ <= rxByte == snvs_pkg::OP_READ;
      end
      if (byteDone && stateQ == snvs_pkg::L_ADDR) begin
        addrByteQ <= 1'b1;
        if (addrByteQ) begin
          addrQ[7:0] <= rxByte;
        end else begin
          addrQ[12:8] <= rxByte[4:0];
        end
      end
      if (byteDone && (stateQ == snvs_pkg::L_WDATA || stateQ == snvs_pkg::L_RDATA)) begin
        addrQ <= addrQ + 13'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // link synchronisers and event post
  // ----------------------------------------------------------------
  always_ff @(posedge sck or posedge sys_rst) begin
    if (sys_rst) begin
      holdS1Q <= 1'b1;
      holdS2Q <= 1'b1;
      statS1Q <= 6'h00;
      statS2Q <= 6'h00;
    end else begin
      holdS1Q <= holdN;
      holdS2Q <= holdS1Q;
      statS1Q <= {~pgS2Q, wpenQ, bpQ, wenQ, busyQ};
      statS2Q <= statS1Q;
    end
  end

  // payload holds still until the next post, at least eight edges later
  always_ff @(posedge sck or posedge sys_rst) begin
    if (sys_rst) begin
      evTogQ <= 1'b0;
      evCodeQ <= snvs_pkg::CELL_RST;
      evDataQ <= snvs_pkg::CELL_RST;
      evAddrQ <= snvs_pkg::ZERO_ADDR;
    end else if (postEv && !holdActive) begin
      evTogQ <= ~evTogQ;
      evCodeQ <= postCode;
      evDataQ <= rxByte;
      evAddrQ <= addrQ;
    end
  end

  // mode follows the clock level sampled as select falls
  always_ff @(negedge csN or posedge sys_rst) begin
    if (sys_rst) begin
      mode3Q <= 1'b0;
    end else begin
      mode3Q <= sck;
    end
  end

  // ----------------------------------------------------------------
  // link transmit, falling sck
  // ----------------------------------------------------------------
  always_ff @(negedge sck or posedge csN) begin
    if (csN) begin
      txQ <= snvs_pkg::CELL_RST;
      soOutQ <= 1'b0;
      soOeQ <= 1'b0;
    end else if (holdActive) begin
      soOeQ <= 1'b0;
    end else if (fallOk) begin
      soOeQ <= sending;
      if (txLoad) begin
        soOutQ <= txSrc[7];
        txQ <= {txSrc[6:0], 1'b0};
      end else begin
        soOutQ <= txQ[7];
        txQ <= {txQ[6:0], 1'b0};
      end
    end
  end

  assign soOut = soOutQ;
  assign soOe = soOeQ;

  // ----------------------------------------------------------------
  // clk-domain decode
  // ----------------------------------------------------------------
  wire evFire = evS2Q ^ evS3Q;
  wire pgRise = pgS2Q & ~pgPrevQ;
  wire pgFall = ~pgS2Q & pgPrevQ;
  wire idle = nvStateQ == snvs_pkg::N_IDLE;
  wire accessOk = evFire & idle & pgS2Q;
  wire pinLock = wpenQ & ~wpS2Q;
  wire lastIdx = idxQ == snvs_pkg::LAST_ADDR;
  wire protHit = (bpQ == 2'h3) | ((bpQ == 2'h2) & evAddrQ[12]) |
                 ((bpQ == 2'h1) & (evAddrQ[12:11] == 2'h3));
  wire memWr = accessOk & (evCodeQ == snvs_pkg::OP_WRITE) & wenQ & ~protHit;
  wire statWr = accessOk & (evCodeQ == snvs_pkg::OP_STATUS_WR) & wenQ & ~pinLock;
  wire doSave = accessOk & (evCodeQ == snvs_pkg::OP_SAVE);
  wire doRestore = accessOk & (evCodeQ == snvs_pkg::OP_RESTORE);
  wire saveDone = (nvStateQ == snvs_pkg::N_PROGRAM) & lastIdx;
  wire restoreDone = (nvStateQ == snvs_pkg::N_COPY) & lastIdx;

  always_comb begin
    nvStateD = nvStateQ;
    if (pgRise) begin
      nvStateD = snvs_pkg::N_CLEAR;
    end else if (pgFall) begin
      nvStateD = (autosaveQ & dirtyQ) ? snvs_pkg::N_ERASE : snvs_pkg::N_IDLE;
    end else begin
      case (nvStateQ)
        snvs_pkg::N_IDLE: begin
          if (doSave) begin
            nvStateD = snvs_pkg::N_ERASE;
          end else if (doRestore) begin
            nvStateD = snvs_pkg::N_CLEAR;
          end
        end
        snvs_pkg::N_ERASE: if (lastIdx) nvStateD = snvs_pkg::N_PROGRAM;
        snvs_pkg::N_PROGRAM: if (lastIdx) nvStateD = snvs_pkg::N_IDLE;
        snvs_pkg::N_CLEAR: if (lastIdx) nvStateD = snvs_pkg::N_COPY;
        snvs_pkg::N_COPY: if (lastIdx) nvStateD = snvs_pkg::N_IDLE;
        default: nvStateD = snvs_pkg::N_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // clk-domain synchronisers and sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pgS1Q <= 1'b0;
      pgS2Q <= 1'b0;
      pgPrevQ <= 1'b0;
      wpS1Q <= 1'b1;
      wpS2Q <= 1'b1;
      evS1Q <= 1'b0;
      evS2Q <= 1'b0;
      evS3Q <= 1'b0;
      nvStateQ <= snvs_pkg::N_IDLE;
      idxQ <= snvs_pkg::ZERO_ADDR;
      busyQ <= 1'b0;
    end else begin
      pgS1Q <= powerGood;
      pgS2Q <= pgS1Q;
      pgPrevQ <= pgS2Q;
      wpS1Q <= wpN;
      wpS2Q <= wpS1Q;
      evS1Q <= evTogQ;
      evS2Q <= evS1Q;
      evS3Q <= evS2Q;
      nvStateQ <= nvStateD;
      idxQ <= (nvStateD != nvStateQ) ? snvs_pkg::ZERO_ADDR : idxQ + 13'h0001;
      busyQ <= nvStateD != snvs_pkg::N_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // control and status bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wenQ <= 1'b0;
      bpQ <= snvs_pkg::BP_RST;
      wpenQ <= snvs_pkg::PIN_EN_RST;
      autosaveQ <= snvs_pkg::AUTOSAVE_RST;
      nvBpQ <= snvs_pkg::BP_RST;
      nvWpenQ <= snvs_pkg::PIN_EN_RST;
      nvAutosaveQ <= snvs_pkg::AUTOSAVE_RST;
      dirtyQ <= 1'b0;
    end else begin
      if (pgRise) begin
        wenQ <= 1'b0;
      end else if (accessOk && evCodeQ == snvs_pkg::OP_WRITE_ON) begin
        wenQ <= 1'b1;
      end else if (accessOk && evCodeQ == snvs_pkg::OP_WRITE_OFF) begin
        wenQ <= 1'b0;
      end
      if (accessOk && evCodeQ == snvs_pkg::OP_AUTOSAVE_ON) begin
        autosaveQ <= 1'b1;
      end else if (accessOk && evCodeQ == snvs_pkg::OP_AUTOSAVE_OFF) begin
        autosaveQ <= 1'b0;
      end else if (restoreDone) begin
        autosaveQ <= nvAutosaveQ;
      end
      if (statWr) begin
        bpQ <= {evDataQ[snvs_pkg::ST_BP_HI], evDataQ[snvs_pkg::ST_BP_LO]};
        wpenQ <= evDataQ[snvs_pkg::ST_PIN_EN];
      end else if (restoreDone) begin
        bpQ <= nvBpQ;
        wpenQ <= nvWpenQ;
      end
      // settings only become nonvolatile through a completed save
      if (saveDone) begin
        nvBpQ <= bpQ;
        nvWpenQ <= wpenQ;
        nvAutosaveQ <= autosaveQ;
      end
      if (memWr) begin
        dirtyQ <= 1'b1;
      end else if (saveDone || restoreDone) begin
        dirtyQ <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // arrays; sys_rst stands for the factory state of all cells
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < snvs_pkg::DEPTH; i++) begin
        sram[i] <= snvs_pkg::CELL_RST;
      end
    end else if (memWr) begin
      sram[evAddrQ] <= evDataQ;
    end else if (nvStateQ == snvs_pkg::N_CLEAR) begin
      sram[idxQ] <= snvs_pkg::CELL_RST;
    end else if (nvStateQ == snvs_pkg::N_COPY) begin
      sram[idxQ] <= nvArr[idxQ];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < snvs_pkg::DEPTH; i++) begin
        nvArr[i] <= snvs_pkg::CELL_RST;
      end
    end else if (nvStateQ == snvs_pkg::N_ERASE) begin
      nvArr[idxQ] <= snvs_pkg::CELL_RST;
    end else if (nvStateQ == snvs_pkg::N_PROGRAM) begin
      nvArr[idxQ] <= sram[idxQ];
    end
  end

  assign busyOut = busyQ;
  assign autosaveOn = autosaveQ;

endmodule : snvs_core

`default_nettype wire

// [tb/snvs_spi_master.sv]
/*
  Behavioural serial bus master that drives the nonvolatile SRAM core.
  Assumes the bench fills txBuf, calls xfer, then reads rxBuf and oeSeen.
*/
`timescale 1ns/1ps
`default_nettype none

module snvs_spi_master (
  output logic sck,
  output logic csN,
  output logic si,
  input wire logic soOut,
  input wire logic soOe
);
  logic [7:0] txBuf [8];
  logic [7:0] rxBuf [8];
  logic oeSeen;

  // select starts low and rises once, so the link side sees a clearing edge
  initial begin
    sck = 1'b0;
    csN = 1'b0;
    si = 1'b0;
    oeSeen = 1'b0;
    #1 csN = 1'b1;
  end

  // ----------------------------------------------------------------
  // one select frame, 30 ns link period
  // ----------------------------------------------------------------
  // clock parks at the mode level between frames; a change of mode gives it an edge while select is still high
  task automatic xfer(input int nBytes, input logic mode3);
    sck = mode3;
    #20 csN = 1'b0;
    oeSeen = 1'b0;
    for (int b = 0; b < nBytes; b++) begin
      for (int i = 7; i >= 0; i--) begin
        #15 sck = 1'b0;
        si = txBuf[b][i];
        #15 sck = 1'b1;
        rxBuf[b][i] = soOe ? soOut : ~soOut; // released line reads inverted
        oeSeen = oeSeen | soOe;
      end
    end
    #15 sck = mode3;
    // stale input bit inverted so an idle line never repeats real data
    si = ~si;
    #15 csN = 1'b1;
    #20;
  endtask : xfer
endmodule : snvs_spi_master
`default_nettype wire

// [tb/snvs_core_checker.sv]
/*
  Port-level assertions for the serial nonvolatile SRAM core.
  Assumes it is bound to snvs_core and that holdN stays high in the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module snvs_core_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic csN,
  input wire logic si,
  input wire logic powerGood,
  input wire logic soOe,
  input wire logic busyOut,
  input wire logic autosaveOn
);
  logic [4:0] bitCnt_q;
  logic [7:0] opc_q;
  logic [15:0] busyLen_q;

  // ----------------------------------------------------------------
  // frame tracking on the link clock
  // ----------------------------------------------------------------
  always_ff @(posedge sck or posedge csN) begin
    if (csN) begin
      bitCnt_q <= 5'h00;
      opc_q <= 8'h00;
    end else begin
      if (bitCnt_q != 5'h1F) begin
        bitCnt_q <= bitCnt_q + 5'h01;
      end
      if (bitCnt_q < 5'h08) begin
        opc_q <= {opc_q[6:0], si};
      end
    end
  end

  // saturates so an aborted sweep followed by a save cannot wrap
  always_ff @(posedge clk) begin
    if (sys_rst || !busyOut) begin
      busyLen_q <= 16'h0000;
    end else if (busyLen_q != 16'hFFFF) begin
      busyLen_q <= busyLen_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_oe_off_deselect: assert property (csN |-> !soOe)
    else $error("serial output enabled while deselected");
  a_oe_after_addr: assert property (soOe |-> (opc_q == snvs_pkg::OP_READ &&
    bitCnt_q >= 5'h18) || (opc_q == snvs_pkg::OP_STATUS_RD && bitCnt_q >= 5'h08))
    else $error("serial output driven outside a read phase");
  a_no_read_busy: assert property (soOe && opc_q == snvs_pkg::OP_READ && powerGood
    |-> !busyOut)
    else $error("array read answered during a sweep");
  a_busy_min_run: assert property ($rose(busyOut) |-> busyOut [*8])
    else $error("busy pulse too short");
  a_busy_full_len: assert property ($fell(busyOut) |-> busyLen_q >= 16'h3FFC)
    else $error("sweep ended before covering the array twice");
  a_power_restore: assert property ($rose(powerGood) |-> ##[1:8] busyOut)
    else $error("no restore after supply rise");
  a_reset_restore: assert property ($past(sys_rst) && powerGood |-> ##[1:8] busyOut)
    else $error("no restore after reset with supply good");
  a_autosave_reset: assert property ($past(sys_rst) |-> autosaveOn && !busyOut)
    else $error("wrong state right after reset");
endmodule : snvs_core_checker

bind snvs_core snvs_core_checker i_snvs_core_checker (
  .clk(clk), .sys_rst(sys_rst), .sck(sck), .csN(csN), .si(si), .powerGood(powerGood),
  .soOe(soOe), .busyOut(busyOut), .autosaveOn(autosaveOn));
`default_nettype wire

// [tb/tb_top.sv]
/*
  Self-checking bench for the serial nonvolatile SRAM core.
  Assumes the checker is bound to the core and the master model drives the link.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int LIMIT = 95000;
  logic clk, sysRst, holdN, wpN, powerGood;
  logic sck, csN, si, soOut, soOe, busyOut, autosaveOn;
  int errorCnt = 0;
  int totalChecks = 0;
  int cycles = 0;
  logic [7:0] d [3];
  logic [12:0] base;

  snvs_core i_snvs_core (.clk(clk), .sys_rst(sysRst), .sck(sck), .csN(csN), .si(si),
    .holdN(holdN), .wpN(wpN), .powerGood(powerGood), .soOut(soOut), .soOe(soOe),
    .busyOut(busyOut), .autosaveOn(autosaveOn));
  snvs_spi_master i_snvs_spi_master (.sck(sck), .csN(csN), .si(si), .soOut(soOut),
    .soOe(soOe));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [12:0] nextAddr(input logic [12:0] a);
    return (a == snvs_pkg::LAST_ADDR) ? snvs_pkg::ZERO_ADDR : a + 13'h0001;
  endfunction : nextAddr

  // top three address bits are random: the core must ignore them
  function automatic logic [7:0] addrHi(input logic [12:0] a);
    return {3'($urandom), a[12:8]};
  endfunction : addrHi

  task automatic reportAndStop();
    $display("checks %0d, mismatches %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : reportAndStop

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic send(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
    input logic [7:0] dat, input int n);
    i_snvs_spi_master.txBuf[0] = op;
    i_snvs_spi_master.txBuf[1] = b1;
    i_snvs_spi_master.txBuf[2] = b2;
    i_snvs_spi_master.txBuf[3] = dat;
    i_snvs_spi_master.xfer(n, 1'($urandom));
    @(posedge clk);
    #1;
  endtask : send

  task automatic readAt(input logic [12:0] a, input int n);
    send(snvs_pkg::OP_READ, addrHi(a), a[7:0], 8'h00, n);
  endtask : readAt

  task automatic waitBusy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busyOut !== lvl && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({7'h00, busyOut}, {7'h00, lvl});
  endtask : waitBusy

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errorCnt++;
      reportAndStop();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    sysRst = 1'b0;
    holdN = 1'b1;
    wpN = 1'b1;
    powerGood = 1'b1;
    void'($urandom(47569));
    // a definite rising edge for the link-side resets, which are asynchronous
    #1 sysRst = 1'b1;
    repeat (3) @(posedge clk);
    #1 sysRst = 1'b0;
    waitBusy(1'b1, 12);
    check({7'h00, autosaveOn}, 8'h01);
    send(snvs_pkg::OP_STATUS_RD, 8'h00, 8'h00, 8'h00, 2);
    check(i_snvs_spi_master.rxBuf[1] & 8'h01, 8'h01);
    waitBusy(1'b0, 17000);
    readAt(13'h0123, 4);
    check(i_snvs_spi_master.rxBuf[3], snvs_pkg::CELL_RST);
    send(snvs_pkg::OP_WRITE_ON, 8'h00, 8'h00, 8'h00, 1);
    base = snvs_pkg::LAST_ADDR - 13'h0001;
    for (int i = 0; i < 3; i++) begin
      d[i] = 8'($urandom);
      i_snvs_spi_master.txBuf[3 + i] = d[i];
    end
    i_snvs_spi_master.xfer(0, 1'b0);
    send(snvs_pkg::OP_WRITE, addrHi(base), base[7:0], d[0], 6);
    readAt(base, 6);
    check({7'h00, i_snvs_spi_master.oeSeen}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      check(i_snvs_spi_master.rxBuf[3 + i], d[i]);
    end
    readAt(nextAddr(nextAddr(base)), 4);
    check(i_snvs_spi_master.rxBuf[3], d[2]);
    send(8'hAA, 8'h03, 8'h00, 8'h00, 4);
    check({7'h00, i_snvs_spi_master.oeSeen}, 8'h00);
    send(snvs_pkg::OP_STATUS_WR, 8'h04, 8'h00, 8'h00, 2);
    send(snvs_pkg::OP_STATUS_RD, 8'h00, 8'h00, 8'h00, 2);
    check(i_snvs_spi_master.rxBuf[1], 8'h06);
    send(snvs_pkg::OP_WRITE, addrHi(13'h17FF), 8'hFF, 8'h5A, 5);
    readAt(13'h17FF, 5);
    check(i_snvs_spi_master.rxBuf[3], 8'h5A);
    check(i_snvs_spi_master.rxBuf[4], snvs_pkg::CELL_RST);
    send(snvs_pkg::OP_STATUS_WR, 8'h00, 8'h00, 8'h00, 2);
    send(snvs_pkg::OP_STATUS_WR, 8'h80, 8'h00, 8'h00, 2);
    wpN = 1'b0;
    send(snvs_pkg::OP_STATUS_WR, 8'h8C, 8'h00, 8'h00, 2);
    send(snvs_pkg::OP_STATUS_RD, 8'h00, 8'h00, 8'h00, 2);
    check(i_snvs_spi_master.rxBuf[1], 8'h82);
    wpN = 1'b1;
    send(snvs_pkg::OP_STATUS_WR, 8'h00, 8'h00, 8'h00, 2);
    send(snvs_pkg::OP_WRITE_OFF, 8'h00, 8'h00, 8'h00, 1);
    send(snvs_pkg::OP_WRITE, addrHi(13'h0040), 8'h40, 8'h3C, 4);
    readAt(13'h0040, 4);
    check(i_snvs_spi_master.rxBuf[3], snvs_pkg::CELL_RST);
    send(snvs_pkg::OP_WRITE_ON, 8'h00, 8'h00, 8'h00, 1);
    send(snvs_pkg::OP_SAVE, 8'h00, 8'h00, 8'h00, 1);
    waitBusy(1'b1, 12);
    readAt(base, 4);
    check({7'h00, i_snvs_spi_master.oeSeen}, 8'h00);
    waitBusy(1'b0, 17000);
    send(snvs_pkg::OP_WRITE, addrHi(base), base[7:0], ~d[0], 4);
    send(snvs_pkg::OP_RESTORE, 8'h00, 8'h00, 8'h00, 1);
    waitBusy(1'b1, 12);
    waitBusy(1'b0, 17000);
    readAt(base, 4);
    check(i_snvs_spi_master.rxBuf[3], d[0]);
    send(snvs_pkg::OP_AUTOSAVE_OFF, 8'h00, 8'h00, 8'h00, 1);
    repeat (6) @(posedge clk);
    #1;
    check({7'h00, autosaveOn}, 8'h00);
    send(snvs_pkg::OP_AUTOSAVE_ON, 8'h00, 8'h00, 8'h00, 1);
    repeat (6) @(posedge clk);
    #1;
    check({7'h00, autosaveOn}, 8'h01);
    powerGood = 1'b0;
    repeat (64) @(posedge clk);
    #1;
    check({7'h00, busyOut}, 8'h00);
    powerGood = 1'b1;
    waitBusy(1'b1, 12);
    waitBusy(1'b0, 17000);
    send(snvs_pkg::OP_WRITE_ON, 8'h00, 8'h00, 8'h00, 1);
    send(snvs_pkg::OP_WRITE, addrHi(13'h0100), 8'h00, 8'($urandom), 4);
    powerGood = 1'b0;
    waitBusy(1'b1, 12);
    waitBusy(1'b0, 17000);
    reportAndStop();
  end
endmodule : tb_top
`default_nettype wire
